//--- rtl/slsr_pkg.sv
/*
  Constants for the serial link status register block: configuration
  offsets, field positions, reset values and the lane width codes.
  Assumes a single 25 MHz core clock and a 16-bit configuration port.
*/
package slsr_pkg;

  // ==========================================================================
  // Configuration offsets (byte addresses)
  localparam logic [7:0] LINK_CTRL_OFFSET   = 8'h7c;
  localparam logic [7:0] LINK_STATUS_OFFSET = 8'h7e;

  // ==========================================================================
  // Link control field positions
  localparam int RETRAIN_REQUEST_BIT = 5;

  // ==========================================================================
  // Link status field positions
  localparam int SLOT_CLOCK_SHARED_BIT = 12;
  localparam int TRAINING_ACTIVE_BIT   = 11;
  localparam int TRAINING_ERROR_BIT    = 10;
  localparam int WIDTH_LSB             = 4;
  localparam int WIDTH_MSB             = 9;
  localparam int SPEED_LSB             = 0;
  localparam int SPEED_MSB             = 3;

  // ==========================================================================
  // Reset values
  localparam logic       SLOT_CLOCK_SHARED_RESET = 1'b1;
  localparam logic       TRAINING_ERROR_RESET    = 1'b0;
  localparam logic [5:0] WIDTH_RESET             = 6'h04;
  localparam logic [3:0] SPEED_RESET             = 4'h1;

  // ==========================================================================
  // Negotiated width codes, one-hot lane count; WIDTH_NONE is zero
  localparam logic [5:0] WIDTH_X1   = 6'h01;
  localparam logic [5:0] WIDTH_X4   = 6'h04;
  localparam logic [5:0] WIDTH_X8   = 6'h08;
  localparam logic [5:0] WIDTH_X16  = 6'h10;
  localparam logic [5:0] WIDTH_NONE = 6'h00;

  // Only defined speed code, 2.5 Gb/s
  localparam logic [3:0] SPEED_2G5 = 4'h1;

endpackage : slsr_pkg

//--- rtl/slsr_wo_bit.sv
/*
  Write-once register bit: takes its reset value, accepts exactly one
  write after reset, then holds. Assumes the write strobe is synchronous
  to clk_in.
*/
`timescale 1ns/10ps
module slsr_wo_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic wr_en_in,
  input  wire logic wdata_in,
  output logic      value_out,
  output logic      locked_out
);

  logic value_reg;
  logic value_next;
  logic locked_reg;
  logic locked_next;

  // ==========================================================================
  // Next state: first write lands and locks
  always_comb begin
    value_next  = value_reg;
    locked_next = locked_reg;
    if (wr_en_in && !locked_reg) begin
      value_next  = wdata_in;
      locked_next = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      value_reg  <= RESET_VAL;
      locked_reg <= 1'b0;
    end else begin
      value_reg  <= value_next;
      locked_reg <= locked_next;
    end
  end

  assign value_out  = value_reg;
  assign locked_out = locked_reg;

endmodule : slsr_wo_bit

//--- rtl/slsr_link_status.sv
/*
  Link status register of one root port, with the retrain request bit of
  the link control register beside it, on the configuration port.
  Assumes the training state machine runs on clk_in and drives the
  training, error and negotiation inputs directly (no synchronisers).
*/
//
// Contract
// (R1) Clock shared bit resets 1, writable once
// (R2) Clock shared: 1 common, 0 independent
// (R3) Firmware clears clock shared when clocks differ
// (R4) Training flag: training state or pending retrain
// (R5) Training error flag sets on error
// (R6) Width field reports negotiated width, resets x4
// (R7) Width only one, four, eight, sixteen lanes
// (R8) Speed field resets 0001, 2.5 Gb/s
// (R9) One-hot width codes, zero if unsupported
// (R10) Retrain write starts retraining, reads zero
// (R11) Width undefined before training finishes
// (R12) Bits 15:13 read zero, ignore writes
`timescale 1ns/10ps
module slsr_link_status #(
  parameter int MAX_LANES = 16
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [1:0]  cfg_be_in,
  input  wire logic [15:0] cfg_wdata_in,
  input  wire logic        ltssm_training_in,
  input  wire logic        training_error_in,
  input  wire logic        training_done_in,
  input  wire logic [5:0]  negotiated_width_in,
  input  wire logic [3:0]  negotiated_speed_in,
  output logic [15:0]      cfg_rdata_out,
  output logic             cfg_rvalid_out,
  output logic             retrain_start_out,
  output logic             slot_clock_shared_out,
  output logic             training_active_out
);

  // ==========================================================================
  // Width code filter
  function automatic logic width_legal(input logic [5:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      slsr_pkg::WIDTH_X1:  ok = (MAX_LANES >= 1);
      slsr_pkg::WIDTH_X4:  ok = (MAX_LANES >= 4);
      slsr_pkg::WIDTH_X8:  ok = (MAX_LANES >= 8);
      slsr_pkg::WIDTH_X16: ok = (MAX_LANES >= 16);
      default:             ok = 1'b0;
    endcase
    return ok;
  endfunction : width_legal

  // Address match for a 16-bit configuration word
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction : hit

  // ==========================================================================
  // Access decode
  logic ctrl_wr;
  logic status_wr;
  logic retrain_wr;
  logic shared_wr;

  assign ctrl_wr    = cfg_wr_in && hit(cfg_addr_in, slsr_pkg::LINK_CTRL_OFFSET);
  assign status_wr  = cfg_wr_in && hit(cfg_addr_in, slsr_pkg::LINK_STATUS_OFFSET);
  // Low byte lane carries the retrain bit
  assign retrain_wr = ctrl_wr && cfg_be_in[0]
                      && cfg_wdata_in[slsr_pkg::RETRAIN_REQUEST_BIT]; // R10
  // High byte lane carries the clock shared bit; bits above it are dropped
  assign shared_wr  = status_wr && cfg_be_in[1]; // R12

  // ==========================================================================
  // Write-once clock shared bit
  logic shared_val;

  slsr_wo_bit #(
    .RESET_VAL (slsr_pkg::SLOT_CLOCK_SHARED_RESET)
  ) u_shared_bit (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .wr_en_in   (shared_wr), // R1
    .wdata_in   (cfg_wdata_in[slsr_pkg::SLOT_CLOCK_SHARED_BIT]),
    .value_out  (shared_val), // R2
    .locked_out ()
  );

  // ==========================================================================
  // Training status state
  logic       pending_reg;
  logic       pending_next;
  logic       active_reg;
  logic       active_next;
  logic       error_reg;
  logic       error_next;
  logic [5:0] width_reg;
  logic [5:0] width_next;
  logic [3:0] speed_reg;
  logic [3:0] speed_next;
  logic       retrain_reg;
  logic       retrain_next;
  logic       shared_reg;

  // Next values of training status
  always_comb begin
    pending_next = pending_reg;
    error_next   = error_reg;
    width_next   = width_reg;
    speed_next   = speed_reg;
    retrain_next = retrain_wr; // R10
    // Pending ends once the state machine enters training
    if (ltssm_training_in) begin
      pending_next = 1'b0; // R4
    end else if (retrain_wr) begin
      pending_next = 1'b1; // R4
    end
    active_next = ltssm_training_in || pending_next; // R4
    // Sticky error, cleared only by reset
    if (training_error_in) begin
      error_next = 1'b1; // R5
    end
    // Capture only legal negotiated values
    if (training_done_in) begin
      if (width_legal(negotiated_width_in)) begin
        width_next = negotiated_width_in; // R6 R7 R9
      end else begin
        width_next = slsr_pkg::WIDTH_NONE; // R9
      end
      if (negotiated_speed_in == slsr_pkg::SPEED_2G5) begin
        speed_next = negotiated_speed_in; // R8
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pending_reg <= 1'b0;
      active_reg  <= 1'b0;
      error_reg   <= slsr_pkg::TRAINING_ERROR_RESET; // R5
      width_reg   <= slsr_pkg::WIDTH_RESET; // R6
      speed_reg   <= slsr_pkg::SPEED_RESET; // R8
      retrain_reg <= 1'b0;
      shared_reg  <= slsr_pkg::SLOT_CLOCK_SHARED_RESET;
    end else begin
      pending_reg <= pending_next;
      active_reg  <= active_next;
      error_reg   <= error_next;
      width_reg   <= width_next;
      speed_reg   <= speed_next;
      retrain_reg <= retrain_next;
      shared_reg  <= shared_val;
    end
  end

  // ==========================================================================
  // Read path
  logic [15:0] status_word;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  // Assembled status word; top three bits stay zero
  always_comb begin
    status_word = 16'h0000; // R12
    status_word[slsr_pkg::SLOT_CLOCK_SHARED_BIT] = shared_val;
    status_word[slsr_pkg::TRAINING_ACTIVE_BIT]   = active_next; // R4
    status_word[slsr_pkg::TRAINING_ERROR_BIT]    = error_reg;
    status_word[slsr_pkg::WIDTH_MSB:slsr_pkg::WIDTH_LSB] = width_reg;
    status_word[slsr_pkg::SPEED_MSB:slsr_pkg::SPEED_LSB] = speed_reg;
  end

  // Read data: status word, zero for control (retrain reads 0) and elsewhere
  always_comb begin
    rdata_next  = 16'h0000; // R10
    rvalid_next = cfg_rd_in;
    if (cfg_rd_in && hit(cfg_addr_in, slsr_pkg::LINK_STATUS_OFFSET)) begin
      rdata_next = status_word;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ==========================================================================
  // Outputs straight from flops
  assign cfg_rdata_out         = rdata_reg;
  assign cfg_rvalid_out        = rvalid_reg;
  assign retrain_start_out     = retrain_reg;
  assign slot_clock_shared_out = shared_reg;
  assign training_active_out   = active_reg;

endmodule : slsr_link_status

//--- sim/slsr_partner.sv
/*
  Training machine stand-in: runs a short training pass after each retrain pulse.
  Assumes the block's clock and reset; widths come from the bench.
*/
`timescale 1ns/10ps
module slsr_partner (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       retrain_in,
  input  wire logic [5:0] width_code_in,
  input  wire logic       fail_in,
  output logic            ltssm_out,
  output logic            error_out,
  output logic            done_out,
  output logic [5:0]      width_out,
  output logic [3:0]      speed_out
);
  logic [3:0] cnt_reg;
  // ==========================================================================
  // Training pass sequencer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) cnt_reg <= 4'h0;
    else if (retrain_in) cnt_reg <= 4'h1;
    else if (cnt_reg != 4'h0) cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
  end
  // Training states, error and result
  assign ltssm_out = (cnt_reg >= 4'h3) && (cnt_reg <= 4'h6);
  assign error_out = fail_in && (cnt_reg == 4'h5);
  assign done_out  = (cnt_reg == 4'h7);
  assign width_out = done_out ? width_code_in : ~width_code_in;
  assign speed_out = done_out ? 4'h1 : 4'he;
endmodule : slsr_partner

//--- sim/slsr_link_status_assertions.sv
/*
  Port-level checks of the link status block.
  Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/10ps
module slsr_chk (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  cfg_addr_in,
  input wire logic        cfg_wr_in,
  input wire logic        cfg_rd_in,
  input wire logic [1:0]  cfg_be_in,
  input wire logic [15:0] cfg_wdata_in,
  input wire logic        ltssm_training_in,
  input wire logic        training_error_in,
  input wire logic [15:0] cfg_rdata_out,
  input wire logic        cfg_rvalid_out,
  input wire logic        retrain_start_out,
  input wire logic        training_active_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================================
  // Error seen on the training side, for the sticky flag checks
  logic err_seen_reg;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      err_seen_reg <= 1'b0;
    end else if (training_error_in) begin
      err_seen_reg <= 1'b1;
    end
  end
  // ==========================================================================
  // Read port, training active and retrain start outputs
  a_read_speed_one: assert property (cfg_rd_in && cfg_addr_in == 8'h7e |=>
    cfg_rvalid_out && cfg_rdata_out[3:0] == 4'h1) else $error("speed field wrong");
  a_reserved_zero: assert property (cfg_rvalid_out |-> cfg_rdata_out[15:13] == 3'h0)
    else $error("reserved bits set");
  a_width_legal: assert property (cfg_rd_in && cfg_addr_in == 8'h7e |=>
    cfg_rdata_out[9:4] inside {6'h00, 6'h01, 6'h04, 6'h08, 6'h10}) else $error("bad width");
  a_train_read: assert property (cfg_rd_in && cfg_addr_in == 8'h7e && ltssm_training_in
    |=> cfg_rdata_out[11]) else $error("training bit low");
  a_train_out: assert property (ltssm_training_in |=> training_active_out)
    else $error("training output low");
  a_error_sticky: assert property (err_seen_reg && cfg_rd_in && cfg_addr_in == 8'h7e |=>
    cfg_rdata_out[10]) else $error("error bit low");
  a_error_clear: assert property (!err_seen_reg && cfg_rd_in && cfg_addr_in == 8'h7e |=>
    !cfg_rdata_out[10]) else $error("error bit set early");
  a_retrain_start: assert property (cfg_wr_in && cfg_addr_in == 8'h7c && cfg_be_in[0] &&
    cfg_wdata_in[5] |=> retrain_start_out) else $error("no retrain pulse");
  a_retrain_cause: assert property (retrain_start_out |-> $past(cfg_wr_in &&
    cfg_addr_in == 8'h7c && cfg_be_in[0] && cfg_wdata_in[5])) else $error("stray retrain");
  a_ctrl_zero: assert property (cfg_rd_in && cfg_addr_in == 8'h7c |=> cfg_rdata_out == 16'h0)
    else $error("control read not zero");
  // Main scenarios
  c_retrain: cover property (retrain_start_out);
  c_error: cover property (training_error_in);
  c_train_read: cover property (cfg_rvalid_out && cfg_rdata_out[11]);
endmodule : slsr_chk
bind slsr_link_status slsr_chk u_slsr_chk (.clk_in, .sys_rst_in, .cfg_addr_in, .cfg_wr_in,
  .cfg_rd_in, .cfg_be_in, .cfg_wdata_in, .ltssm_training_in, .training_error_in,
  .cfg_rdata_out, .cfg_rvalid_out, .retrain_start_out, .training_active_out);

//--- sim/tb.sv
/*
  Self-checking bench of the link status block with the training stand-in.
  Assumes the 25 MHz clock and 16-cycle reset at start.
*/
`timescale 1ns/10ps
module tb;
  logic clk_in = 0, sys_rst_in = 1, cfg_wr_in = 0, cfg_rd_in = 0, fail = 0;
  logic [7:0]  cfg_addr_in = 8'h00;
  logic [1:0]  cfg_be_in = 2'h0;
  logic [15:0] cfg_wdata_in = 16'h0, cfg_rdata_out;
  logic [5:0]  wcode = 6'h04, negotiated_width_in;
  logic [3:0]  negotiated_speed_in;
  logic cfg_rvalid_out, retrain_start_out, slot_clock_shared_out, training_active_out;
  logic ltssm_training_in, training_error_in, training_done_in;
  int n_mismatch = 0, n_compared = 0;
  slsr_link_status u_slsr_link_status (.clk_in, .sys_rst_in, .cfg_addr_in, .cfg_wr_in,
    .cfg_rd_in, .cfg_be_in, .cfg_wdata_in, .ltssm_training_in, .training_error_in,
    .training_done_in, .negotiated_width_in, .negotiated_speed_in, .cfg_rdata_out,
    .cfg_rvalid_out, .retrain_start_out, .slot_clock_shared_out, .training_active_out);
  slsr_partner u_slsr_partner (.clk_in, .sys_rst_in, .retrain_in(retrain_start_out),
    .width_code_in(wcode), .fail_in(fail), .ltssm_out(ltssm_training_in),
    .error_out(training_error_in), .done_out(training_done_in),
    .width_out(negotiated_width_in), .speed_out(negotiated_speed_in));
  // ==========================================================================
  // Clock and watchdog
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end
  // ==========================================================================
  // Shared access and compare
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [1:0] be,
                     input logic [15:0] d);
    @(posedge clk_in);
    {cfg_wr_in, cfg_rd_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} <= {wr, !wr, a, be, d};
    @(posedge clk_in);
    {cfg_wr_in, cfg_rd_in} <= 2'b00;
    #1;
  endtask : cfg
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    cfg(0, 8'h7e, 2'h3, 16'h0);
    chk(cfg_rdata_out, 16'h1041);
    chk({15'h0, cfg_rvalid_out}, 16'h1);
    chk({15'h0, slot_clock_shared_out}, 16'h1);
  endtask : t_reset
  task automatic t_write_once();
    cfg(1, 8'h7e, 2'h2, 16'hefff);
    cfg(0, 8'h7e, 2'h3, 16'h0);
    chk(cfg_rdata_out, 16'h0041);
    cfg(1, 8'h7e, 2'h2, 16'h1000);
    cfg(0, 8'h7e, 2'h3, 16'h0);
    chk(cfg_rdata_out, 16'h0041);
    chk({15'h0, slot_clock_shared_out}, 16'h0);
  endtask : t_write_once
  task automatic t_retrain(input logic [5:0] code, input logic [5:0] exp, input logic err);
    wcode <= code;
    cfg(1, 8'h7c, 2'h1, 16'h0020);
    chk({15'h0, retrain_start_out}, 16'h1);
    chk({15'h0, training_active_out}, 16'h1);
    // Pending retrain, training not yet begun
    cfg(0, 8'h7e, 2'h3, 16'h0);
    chk({15'h0, cfg_rdata_out[11]}, 16'h1);
    cfg(0, 8'h7c, 2'h3, 16'h0);
    chk(cfg_rdata_out, 16'h0);
    chk({15'h0, cfg_rdata_out[11]}, 16'h0);
    cfg(0, 8'h7e, 2'h3, 16'h0);
    chk({15'h0, cfg_rdata_out[11]}, 16'h1);
    for (int i = 0; i < 30 && training_done_in !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    cfg(0, 8'h7e, 2'h3, 16'h0);
    chk({4'h0, cfg_rdata_out[11:0]}, {4'h0, 1'b0, err, exp, slsr_pkg::SPEED_2G5});
    chk({15'h0, training_active_out}, 16'h0);
  endtask : t_retrain
  task automatic t_error();
    fail <= 1'b1;
    t_retrain(slsr_pkg::WIDTH_X8, slsr_pkg::WIDTH_X8, 1'b1);
    fail <= 1'b0;
    t_retrain(slsr_pkg::WIDTH_X1, slsr_pkg::WIDTH_X1, 1'b1);
  endtask : t_error
  // ==========================================================================
  // Verdict and main sequence
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_write_once();
    t_retrain(slsr_pkg::WIDTH_X1, slsr_pkg::WIDTH_X1, 1'b0);
    t_retrain(slsr_pkg::WIDTH_X16, slsr_pkg::WIDTH_X16, 1'b0);
    t_retrain(slsr_pkg::WIDTH_X4, slsr_pkg::WIDTH_X4, 1'b0);
    t_retrain(6'h03, slsr_pkg::WIDTH_NONE, 1'b0);
    t_error();
    test_done();
  end
endmodule : tb
